// >>> rtl/drive_prot_pkg.sv
// constants, types and register map of the drive protection supervisor
package drive_prot_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 40_000_000;
    localparam int TICK_MS       = 10;
    localparam int TICK_CYC_DEF  = CLK_HZ / 1000 * TICK_MS;
    localparam int TICK_PER_DSEC = 100 / TICK_MS;
    localparam int TICK_PER_SEC  = 1000 / TICK_MS;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_LEVEL = 8'h04;
    localparam logic [7:0] OFS_TIME  = 8'h08;
    localparam logic [7:0] OFS_THERM = 8'h0c;
    localparam logic [7:0] OFS_TLVL  = 8'h10;
    localparam logic [7:0] OFS_ROUTE = 8'h14;
    localparam logic [7:0] OFS_STAT  = 8'h18;
    localparam logic [7:0] OFS_CLR   = 8'h1c;
    // ------------------------------------------------------------
    // reset values and fixed thresholds
    // ------------------------------------------------------------
    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] LEVEL_RST = 32'h0000_0000;
    localparam logic [31:0] TIME_RST  = 32'h0000_0000;
    localparam logic [31:0] THERM_RST = 32'h0001_0000;
    localparam logic [31:0] TLVL_RST  = 32'h0064_6464;
    localparam logic [31:0] ROUTE_RST = 32'h0000_0000;
    localparam logic [8:0]  OPL_MIN_PCT = 9'h00a;
    localparam logic [8:0]  GF_PCT      = 9'h032;
    localparam logic [7:0]  DI_PERMIT   = 8'h3a;
    localparam logic [7:0]  RLY_TQ_A    = 8'h0c;
    localparam logic [7:0]  RLY_TQ_B    = 8'h19;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {DET_OFF = 2'b00, DET_AT_SPEED = 2'b01, DET_RUN = 2'b10} det_sel_t;
    typedef enum logic [1:0] {ACT_RAMP = 2'b00, ACT_ALARM = 2'b01, ACT_COAST = 2'b10} tq_act_t;
    typedef enum logic [1:0] {EXT_RAMP = 2'b00, EXT_COAST = 2'b01, EXT_GO = 2'b10} ext_act_t;
    typedef enum logic [1:0] {FAN_RUN = 2'b00, FAN_ALWAYS = 2'b01, FAN_HOT = 2'b10} fan_mode_t;
    typedef enum logic [1:0] {OH_OFF = 2'b00, OH_RAMP = 2'b01, OH_COAST = 2'b10,
                              OH_GO = 2'b11} oh_sel_t;
    typedef enum logic [3:0] {
        FC_NONE = 4'h0, FC_OPL = 4'h1, FC_GF = 4'h2, FC_OH = 4'h3,
        FC_OT = 4'h4, FC_LT = 4'h5, FC_EXT = 4'h6
    } fault_code_t;
    typedef struct packed {
        logic [8:0] current_pct;
        logic [8:0] torque_pct;
        logic [8:0] leakage_pct;
        logic [7:0] therm_dv;
        logic       phase_missing;
        logic       running;
        logic       freq_reached;
        logic       ext_fault;
        logic       run_permit;
        logic       heatsink_hot;
    } sense_t;
endpackage

// >>> rtl/drive_prot_supervisor.sv
// protection supervisor: fault detection, stop requests, relays and fan
//
// Notes on behaviour
// RULE_01: output phase loss trips output and contact
// RULE_02: phase loss ignored below ten percent current
// RULE_03: over-torque arming off, at-speed or run
// RULE_04: over-torque after level held for time
// RULE_05: over-torque acts ramp, alarm or coast
// RULE_06: low-torque arming off, at-speed or run
// RULE_07: low-torque after below level for time
// RULE_08: low-torque acts ramp, alarm or coast
// RULE_09: percent base is current or torque
// RULE_10: relay codes 12/25 show torque detection
// RULE_11: leakage over half rating coasts, faults
// RULE_12: external fault ramps, coasts or continues
// RULE_13: external fault watched always or running
// RULE_14: permit input code 58 stops drive
// RULE_15: fan mode 0 follows run plus delay; code also turns it on while heat-sink hot
// RULE_16: fan mode 1 always on
// RULE_17: fan mode 2 follows heat-sink plus delay
// RULE_18: overheat off, ramp, coast or continue
// RULE_19: thermistor voltage low-pass filtered
// RULE_20: overheat delay and three voltage levels
// RULE_21: mode 3 warns, coasts after delay
// RULE_22: overheat clears below restart level
// RULE_23: timers restart when condition breaks
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/10ps
module drive_prot_supervisor #(
    parameter int TICK_CYCLES = drive_prot_pkg::TICK_CYC_DEF
) (
    input  wire logic                   core_clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic [7:0]             addr_i,
    input  wire logic [31:0]            wr_data_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [31:0]            rd_data_o,
    input  wire drive_prot_pkg::sense_t sense_i,
    output logic                        output_off_o,
    output logic                        ramp_stop_o,
    output logic                        coast_stop_o,
    output logic                        fault_contact_o,
    output logic                        alarm_o,
    output logic      [3:0]             fault_code_o,
    output logic                        motor_temp_warning_o,
    output logic                        relay_output_one_o,
    output logic                        relay_output_two_o,
    output logic                        fan_on_o
);
    // ------------------------------------------------------------
    // input synchroniser
    // ------------------------------------------------------------
    // words are treated as slow analog readings; a torn sample lasts one cycle
    drive_prot_pkg::sense_t sense_q1;
    drive_prot_pkg::sense_t s;
    always_ff @(posedge core_clk_i) begin
        sense_q1 <= sense_i;
        s        <= sense_q1;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] ctrl;
    logic [31:0] level;
    logic [31:0] times;
    logic [31:0] therm;
    logic [31:0] tlvl;
    logic [31:0] route;
    logic        clr_req;
    logic [31:0] status;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ctrl  <= drive_prot_pkg::CTRL_RST;
            level <= drive_prot_pkg::LEVEL_RST;
            times <= drive_prot_pkg::TIME_RST;
            therm <= drive_prot_pkg::THERM_RST;
            tlvl  <= drive_prot_pkg::TLVL_RST;
            route <= drive_prot_pkg::ROUTE_RST;
        end else if (wr_i) begin
            case (addr_i)
                drive_prot_pkg::OFS_CTRL:  ctrl  <= wr_data_i;
                drive_prot_pkg::OFS_LEVEL: level <= wr_data_i;
                drive_prot_pkg::OFS_TIME:  times <= wr_data_i;
                drive_prot_pkg::OFS_THERM: therm <= wr_data_i;
                drive_prot_pkg::OFS_TLVL:  tlvl  <= wr_data_i;
                drive_prot_pkg::OFS_ROUTE: route <= wr_data_i;
                default: ;
            endcase
        end
    end
    assign clr_req = wr_i && addr_i == drive_prot_pkg::OFS_CLR && wr_data_i[0];

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i)
            rd_data_o <= 32'h0000_0000;
        else if (rd_i) begin
            case (addr_i)
                drive_prot_pkg::OFS_CTRL:  rd_data_o <= ctrl;
                drive_prot_pkg::OFS_LEVEL: rd_data_o <= level;
                drive_prot_pkg::OFS_TIME:  rd_data_o <= times;
                drive_prot_pkg::OFS_THERM: rd_data_o <= therm;
                drive_prot_pkg::OFS_TLVL:  rd_data_o <= tlvl;
                drive_prot_pkg::OFS_ROUTE: rd_data_o <= route;
                drive_prot_pkg::OFS_STAT:  rd_data_o <= status;
                default:                   rd_data_o <= 32'h0000_0000;
            endcase
        end else
            rd_data_o <= 32'h0000_0000;
    end

    // control fields
    logic      opl_en;
    logic      gf_en;
    logic      ext_det;
    logic      permit_coast;
    logic      vector_mode;
    logic [1:0] ext_act;
    logic [1:0] fan_mode;
    logic [1:0] oh_sel;
    assign opl_en       = ctrl[0];
    assign gf_en        = ctrl[9];
    assign ext_act      = ctrl[11:10];
    assign ext_det      = ctrl[12];
    assign permit_coast = ctrl[13];
    assign fan_mode     = ctrl[15:14];
    assign oh_sel       = ctrl[17:16];
    assign vector_mode  = ctrl[18];

    // ------------------------------------------------------------
    // time base
    // ------------------------------------------------------------
    logic [31:0] tick_cnt;
    logic        tick;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || tick)
            tick_cnt <= 32'h0000_0000;
        else
            tick_cnt <= tick_cnt + 32'h0000_0001;
    end
    assign tick = tick_cnt == 32'(TICK_CYCLES - 1);

    // ------------------------------------------------------------
    // phase loss and ground fault
    // ------------------------------------------------------------
    logic opl_flt;
    logic gf_flt;
    logic opl_set;
    logic gf_set;
    assign opl_set = opl_en && s.phase_missing
                     && s.current_pct >= drive_prot_pkg::OPL_MIN_PCT; // see RULE_01 RULE_02
    assign gf_set  = gf_en && s.leakage_pct > drive_prot_pkg::GF_PCT; // see RULE_11
    // set wins over a clear in the same cycle
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            opl_flt <= 1'b0;
            gf_flt  <= 1'b0;
        end else begin
            opl_flt <= opl_set || (opl_flt && !clr_req);
            gf_flt  <= gf_set || (gf_flt && !clr_req);
        end
    end

    // ------------------------------------------------------------
    // over-torque (0) and low-torque (1) detectors
    // ------------------------------------------------------------
    logic [8:0] load_pct;
    logic [1:0] tq_flt;
    logic [1:0] tq_coast;
    logic [1:0] tq_alm;
    logic [1:0] tq_cond;
    logic [9:0] tq_cnt [2];
    assign load_pct = vector_mode ? s.torque_pct : s.current_pct; // see RULE_09

    for (genvar g = 0; g < 2; g++) begin : g_tq
        logic [1:0] sel;
        logic [1:0] act;
        logic [8:0] lvl;
        logic [9:0] target;
        logic       armed;
        logic       hit;
        assign sel    = ctrl[4*g+2 -: 2];
        assign act    = ctrl[4*g+4 -: 2];
        assign lvl    = level[16*g+8 -: 9];
        assign target = 10'(times[8*g+6 -: 7] * drive_prot_pkg::TICK_PER_DSEC);
        assign armed  = s.running && (sel == drive_prot_pkg::DET_RUN
                        || (sel == drive_prot_pkg::DET_AT_SPEED
                            && s.freq_reached)); // see RULE_03 RULE_06
        assign tq_cond[g] = armed && (g == 0 ? load_pct > lvl
                                             : load_pct < lvl); // see RULE_04 RULE_07
        assign hit = tq_cond[g] && tq_cnt[g] >= target;
        always_ff @(posedge core_clk_i) begin
            if (!rst_n_i || !tq_cond[g])
                tq_cnt[g] <= 10'h000; // see RULE_23
            else if (tick && tq_cnt[g] < target)
                tq_cnt[g] <= tq_cnt[g] + 10'h001;
        end
        always_ff @(posedge core_clk_i) begin
            if (!rst_n_i) begin
                tq_flt[g]   <= 1'b0;
                tq_coast[g] <= 1'b0;
                tq_alm[g]   <= 1'b0;
            end else begin
                tq_alm[g] <= hit && act == drive_prot_pkg::ACT_ALARM; // see RULE_05 RULE_08
                if (hit && act != drive_prot_pkg::ACT_ALARM) begin
                    tq_flt[g]   <= 1'b1;
                    tq_coast[g] <= act == drive_prot_pkg::ACT_COAST;
                end else if (clr_req) begin
                    tq_flt[g]   <= 1'b0;
                    tq_coast[g] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // external fault and run permit
    // ------------------------------------------------------------
    logic ext_flt;
    logic ext_alm;
    logic ext_seen;
    logic permit_stop;
    assign ext_seen = s.ext_fault && (!ext_det || s.running); // see RULE_13
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ext_flt <= 1'b0;
            ext_alm <= 1'b0;
        end else begin
            ext_alm <= ext_seen && ext_act == drive_prot_pkg::EXT_GO; // see RULE_12
            ext_flt <= (ext_seen && ext_act != drive_prot_pkg::EXT_GO)
                       || (ext_flt && !clr_req);
        end
    end
    assign permit_stop = route[23:16] == drive_prot_pkg::DI_PERMIT
                         && !s.run_permit; // see RULE_14

    // ------------------------------------------------------------
    // thermistor filter and motor overheat
    // ------------------------------------------------------------
    logic [15:0]        filt;
    logic signed [16:0] diff;
    logic [8:0]         tc;
    logic [7:0]         filt_v;
    assign tc     = therm[8:0];
    assign diff   = $signed({1'b0, s.therm_dv, 8'h00}) - $signed({1'b0, filt});
    assign filt_v = filt[15:8];
    // divide each tick trades area for a true first-order response
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i)
            filt <= 16'h0000;
        else if (tc == 9'h000)
            filt <= {s.therm_dv, 8'h00};
        else if (tick)
            filt <= 16'($signed({1'b0, filt}) + diff / $signed({1'b0, tc})); // see RULE_19
    end

    logic [14:0] oh_cnt;
    logic [14:0] oh_target;
    logic        oh_cond;
    logic        oh_flt;
    logic        oh_set;
    logic        oh_warn;
    assign oh_target = 15'(therm[24:16] * drive_prot_pkg::TICK_PER_SEC); // see RULE_20
    assign oh_cond   = oh_sel == drive_prot_pkg::OH_GO && filt_v > {1'b0, tlvl[6:0]};
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || !oh_cond)
            oh_cnt <= 15'h0000; // see RULE_23
        else if (tick && oh_cnt < oh_target)
            oh_cnt <= oh_cnt + 15'h0001;
    end
    assign oh_warn = oh_sel != drive_prot_pkg::OH_OFF
                     && filt_v > {1'b0, tlvl[22:16]}; // see RULE_21
    assign oh_set  = (oh_warn && oh_sel != drive_prot_pkg::OH_GO)
                     || (oh_cond && oh_cnt >= oh_target); // see RULE_18 RULE_21
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i)
            oh_flt <= 1'b0;
        else if (oh_set)
            oh_flt <= 1'b1;
        else if (oh_sel == drive_prot_pkg::OH_OFF || filt_v < {1'b0, tlvl[14:8]})
            oh_flt <= 1'b0; // see RULE_22
    end

    // ------------------------------------------------------------
    // fan control
    // ------------------------------------------------------------
    logic [15:0] fan_cnt;
    logic [15:0] fan_target;
    logic        fan_idle;
    logic        fan_want;
    assign fan_target = 16'(times[25:16] * drive_prot_pkg::TICK_PER_SEC);
    assign fan_idle   = fan_mode == drive_prot_pkg::FAN_HOT ? !s.heatsink_hot : !s.running;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || !fan_idle)
            fan_cnt <= 16'h0000;
        else if (tick && fan_cnt < fan_target)
            fan_cnt <= fan_cnt + 16'h0001;
    end
    always_comb begin
        case (fan_mode)
            drive_prot_pkg::FAN_RUN:    fan_want = s.running || s.heatsink_hot
                                                   || fan_cnt < fan_target; // see RULE_15
            drive_prot_pkg::FAN_ALWAYS: fan_want = 1'b1; // see RULE_16
            drive_prot_pkg::FAN_HOT:    fan_want = s.heatsink_hot
                                                   || fan_cnt < fan_target; // see RULE_17
            default:                    fan_want = s.running;
        endcase
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic        any_coast;
    logic        any_ramp;
    logic        any_flt;
    logic        tq_state;
    logic [3:0]  code;
    assign tq_state  = |tq_flt || |tq_alm;
    assign any_coast = gf_flt || opl_flt || |tq_coast
                       || (ext_flt && ext_act == drive_prot_pkg::EXT_COAST)
                       || (oh_flt && oh_sel != drive_prot_pkg::OH_RAMP)
                       || (permit_stop && permit_coast); // see RULE_11 RULE_14
    assign any_ramp  = (|(tq_flt & ~tq_coast))
                       || (ext_flt && ext_act == drive_prot_pkg::EXT_RAMP)
                       || (oh_flt && oh_sel == drive_prot_pkg::OH_RAMP)
                       || (permit_stop && !permit_coast); // see RULE_12 RULE_18
    assign any_flt   = opl_flt || gf_flt || oh_flt || |tq_flt || ext_flt;
    always_comb begin
        if (opl_flt)        code = drive_prot_pkg::FC_OPL;
        else if (gf_flt)    code = drive_prot_pkg::FC_GF;
        else if (oh_flt)    code = drive_prot_pkg::FC_OH;
        else if (tq_flt[0]) code = drive_prot_pkg::FC_OT;
        else if (tq_flt[1]) code = drive_prot_pkg::FC_LT;
        else if (ext_flt)   code = drive_prot_pkg::FC_EXT;
        else                code = drive_prot_pkg::FC_NONE;
    end
    assign status = {16'h0000, 1'b0, fan_on_o, oh_warn, ext_alm, tq_alm,
                     permit_stop, any_flt, filt_v};

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            output_off_o         <= 1'b0;
            ramp_stop_o          <= 1'b0;
            coast_stop_o         <= 1'b0;
            fault_contact_o      <= 1'b0;
            alarm_o              <= 1'b0;
            fault_code_o         <= 4'h0;
            motor_temp_warning_o <= 1'b0;
            relay_output_one_o   <= 1'b0;
            relay_output_two_o   <= 1'b0;
            fan_on_o             <= 1'b0;
        end else begin
            output_off_o         <= opl_flt; // see RULE_01
            coast_stop_o         <= any_coast;
            ramp_stop_o          <= any_ramp && !any_coast;
            fault_contact_o      <= any_flt;
            alarm_o              <= |tq_alm || ext_alm || oh_warn;
            fault_code_o         <= code;
            motor_temp_warning_o <= oh_warn;
            relay_output_one_o   <= tq_state && (route[7:0] == drive_prot_pkg::RLY_TQ_A
                                   || route[7:0] == drive_prot_pkg::RLY_TQ_B); // see RULE_10
            relay_output_two_o   <= tq_state && (route[15:8] == drive_prot_pkg::RLY_TQ_A
                                   || route[15:8] == drive_prot_pkg::RLY_TQ_B);
            fan_on_o             <= fan_want;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    opl_trip_a: assert property (opl_set |=> ##1 (output_off_o && fault_contact_o)) // see RULE_01
        else $error("phase loss did not trip output");
    opl_floor_a: assert property ($rose(opl_flt) |-> $past(s.current_pct) >= 9'h00a) // see RULE_02
        else $error("phase loss tripped below current floor");
    tq_restart_a: assert property (!tq_cond[0] |=> tq_cnt[0] == 10'h000) // see RULE_23
        else $error("over-torque timer kept count");
    gf_coast_a: assert property (gf_set |=> ##1 coast_stop_o) // see RULE_11
        else $error("ground fault did not coast");
    ext_run_a: assert property ((ext_det && !s.running && !ext_flt) |=> !ext_flt) // see RULE_13
        else $error("external fault seen while stopped");
    fan_always_a: assert property (fan_mode == 2'b01 |=> fan_on_o) // see RULE_16
        else $error("fan off in permanent mode");
    oh_clear_a: assert property ((oh_flt && !oh_set // see RULE_22
                                  && filt_v < {1'b0, tlvl[14:8]}) |=> !oh_flt)
        else $error("overheat fault did not clear");
    permit_stop_a: assert property ((permit_stop && permit_coast) |=> coast_stop_o) // see RULE_14
        else $error("permit withdrawal did not coast");
    ot_alarm_run_a: assert property ((tq_alm[0] && !any_coast && !any_ramp)
                                     |=> !coast_stop_o && !ramp_stop_o) // see RULE_05
        else $error("over-torque alarm stopped the drive");

    tq_trip_c: cover property ($rose(tq_flt[0]));
    lt_alarm_c: cover property ($rose(tq_alm[1]));
    oh_cycle_c: cover property ($rose(oh_flt) ##[1:1000] $fell(oh_flt));
    fan_off_c: cover property ($fell(fan_on_o));
endmodule

// >>> testbench/drive_protection_supervisor_test.sv
// self-checking bench for the drive protection supervisor
`timescale 1ns/10ps
module drive_protection_supervisor_test;
    logic                   core_clk_i;
    logic                   rst_n_i;
    logic [7:0]             addr_i;
    logic [31:0]            wr_data_i;
    logic                   wr_i;
    logic                   rd_i;
    logic [31:0]            rd_data_o;
    drive_prot_pkg::sense_t cmd;
    drive_prot_pkg::sense_t sense;
    logic                   off, ramp, coast, contact, alarm, warn, rly1, rly2, fan;
    logic [3:0]             code;
    int                     miscompares, samples_checked, cyc, cur;
    logic [31:0]            seed;
    int                     exp_q[$];

    sense_model model (.core_clk_i(core_clk_i), .cmd_i(cmd), .sense_o(sense));
    drive_prot_supervisor #(.TICK_CYCLES(4)) dut (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .sense_i(sense),
        .output_off_o(off), .ramp_stop_o(ramp), .coast_stop_o(coast),
        .fault_contact_o(contact), .alarm_o(alarm), .fault_code_o(code),
        .motor_temp_warning_o(warn), .relay_output_one_o(rly1),
        .relay_output_two_o(rly2), .fan_on_o(fan));

    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1 chk(rd_data_o, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------
    // hang guard
    // ------------------------------------------------------------
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 8000) begin
            miscompares++;
            final_report();
        end
    end

    initial begin
        {addr_i, wr_data_i, wr_i, rd_i, cmd} = '0;
        seed = 32'h8fc08af1;
        rst_n_i = 1'b0;
        repeat (5) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        rd(drive_prot_pkg::OFS_THERM, drive_prot_pkg::THERM_RST);
        rd(drive_prot_pkg::OFS_TLVL, drive_prot_pkg::TLVL_RST);
        rd(8'h20, 32'h0);
        $display("test registers done");
        // phase loss with random current, model queue holds expected trips
        wr(drive_prot_pkg::OFS_CTRL, 32'h1);
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            cur = (i == 0) ? 9 : (i == 1) ? 10 : int'(seed % 30);
            exp_q.push_back(cur >= 10);
            @(posedge core_clk_i);
            cmd.current_pct <= 9'(cur);
            cmd.phase_missing <= 1'b1;
            settle(8);
            chk(off, exp_q[0]);
            chk(contact, exp_q[0]);
            chk(code, exp_q.pop_front() ? 4'h1 : 4'h0);
            @(posedge core_clk_i);
            cmd.phase_missing <= 1'b0;
            // clear only once the synchronised input has dropped, else set wins
            settle(4);
            wr(drive_prot_pkg::OFS_CLR, 32'h1);
            settle(6);
            chk(off, 1'b0);
        end
        $display("test phase loss done");
        // leakage at exactly half does not trip, one above does
        wr(drive_prot_pkg::OFS_CTRL, 32'h200);
        cmd.leakage_pct <= 9'd50;
        settle(8);
        chk(code, 4'h0);
        @(posedge core_clk_i);
        cmd.leakage_pct <= 9'd51;
        settle(8);
        chk({coast, contact, code}, {2'b11, 4'h2});
        @(posedge core_clk_i);
        cmd.leakage_pct <= 9'd0;
        settle(4);
        wr(drive_prot_pkg::OFS_CLR, 32'h1);
        $display("test ground fault done");
        // over-torque alarm mode, interrupted once, routed to both relays
        wr(drive_prot_pkg::OFS_LEVEL, 32'd100);
        wr(drive_prot_pkg::OFS_TIME, 32'h1);
        wr(drive_prot_pkg::OFS_ROUTE, 32'h0000_190c);
        wr(drive_prot_pkg::OFS_CTRL, 32'h4000 | 32'h0c);
        settle(6);
        chk(fan, 1'b1);
        @(posedge core_clk_i);
        cmd.running <= 1'b1;
        cmd.current_pct <= 9'd150;
        settle(30);
        @(posedge core_clk_i);
        cmd.current_pct <= 9'd50;
        settle(4);
        @(posedge core_clk_i);
        cmd.current_pct <= 9'd150;
        settle(30);
        chk(alarm, 1'b0);
        settle(30);
        chk({alarm, rly1, rly2}, 3'b111);
        chk(code, 4'h0);
        chk({coast, ramp}, 2'b00);
        $display("test over-torque done");
        // thermistor: warn 2.0 V, restart 1.0 V, protect 10.0 V, no filter
        wr(drive_prot_pkg::OFS_TLVL, 32'h0014_0a64);
        wr(drive_prot_pkg::OFS_CTRL, 32'h0003_4000);
        @(posedge core_clk_i);
        cmd.therm_dv <= 8'd50;
        settle(8);
        chk({warn, alarm, coast, code}, {3'b110, 4'h0});
        wr(drive_prot_pkg::OFS_CTRL, 32'h0002_4000);
        settle(6);
        chk({coast, contact, code}, {2'b11, 4'h3});
        @(posedge core_clk_i);
        cmd.therm_dv <= 8'd0;
        settle(8);
        chk({contact, warn, code}, {2'b00, 4'h0});
        $display("test overheat done");
        final_report();
    end
endmodule

// >>> testbench/sense_model.sv
// behavioural sensor front end feeding the supervisor
`timescale 1ns/10ps
module sense_model (
    input  wire logic                   core_clk_i,
    input  wire drive_prot_pkg::sense_t cmd_i,
    output drive_prot_pkg::sense_t      sense_o
);
    // ------------------------------------------------------------
    // sensor sampling
    // ------------------------------------------------------------
    // one flop of converter latency; current, torque and leakage in percent, thermistor in decivolts
    always_ff @(posedge core_clk_i) begin
        sense_o <= cmd_i;
    end
endmodule
